/* rtl/rci_interlock.sv */
// top of the relay channel interlock: request handling and switch drives
//
// Notes on behaviour
// - exactly 24 switch drives: 20 bank switches plus 4 tree switches.
// - one drive bit per switch actuates its high, low and guard relays.
// - channels 0..9 pick the lower bank, 10..19 the upper bank.
// - closing a bank channel opens any other closed channel of that bank.
// - four tree switches: two sense bus, two source bus.
// - closing a tree switch opens the other one of its type.
// - channel 91 is bank sense tree, 94 is bank source tree.
// - channel 92 is thermistor sense tree, 93 thermistor source tree.
// - banks reach the backplane only through a closed bank tree switch.
// - isolation select in disable position cuts tree outputs from backplane.
// - a card reset request opens every bank and tree switch.
`timescale 1ns/1ps
module rci_interlock
  import rci_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // channel requests from the mainframe controller
  input wire rci_pkg::rci_op_t req_op,
  input wire logic [6:0] req_chan,
  // static isolation select, high means the disable position
  input wire logic backplane_isolate_position,
  // relay drives, one bit per three-relay switch
  output logic [19:0] bank_sw_drive,
  output logic [3:0] tree_sw_drive,
  // tree connection to the backplane after isolation
  output logic [3:0] tree_backplane_drive,
  // banks have a live path to the sense or source bus
  output logic bank_sense_live,
  output logic bank_source_live,
  // request was a reset, or a close or open of a defined channel
  output logic req_accepted
);
  import rci_pkg::*;

  // =========================================
  // switch state
  logic [19:0] bank_reg;
  logic [19:0] bank_next;
  logic [3:0] tree_reg;
  logic [3:0] tree_next;
  logic [3:0] tree_out_reg;
  logic sense_live_reg;
  logic source_live_reg;
  logic accepted_reg;
  rci_decode_if dec_bus ();

  rci_chan_decode u_decode (
    .chan(req_chan),
    .dec(dec_bus.dec)
  );

  // one-hot of a bank index inside a 10-bit bank
  function automatic logic [9:0] rci_onehot10(input logic [3:0] idx);
    rci_onehot10 = 10'h001 << idx;
  endfunction

  // the other tree switch of the same type (sense pairs 0/1, source 2/3)
  function automatic logic [1:0] rci_tree_peer(input logic [1:0] idx);
    rci_tree_peer = {idx[1], ~idx[0]};
  endfunction

  // =========================================
  // next bank state
  always_comb begin
    bank_next = bank_reg;
    if (req_op == RCI_OP_RESET) begin
      bank_next = RCI_BANK_RESET;
    end else if (dec_bus.bank_hit && req_op == RCI_OP_CLOSE) begin
      // the whole bank is replaced, so any earlier closed channel opens
      if (dec_bus.upper_bank) begin
        bank_next[19:10] = rci_onehot10(dec_bus.bank_index);
      end else begin
        bank_next[9:0] = rci_onehot10(dec_bus.bank_index);
      end
    end else if (dec_bus.bank_hit && req_op == RCI_OP_OPEN) begin
      bank_next[5'(dec_bus.bank_index) + (dec_bus.upper_bank ? 5'h0A : 5'h00)] = 1'b0;
    end
  end

  // =========================================
  // next tree state
  always_comb begin
    tree_next = tree_reg;
    if (req_op == RCI_OP_RESET) begin
      tree_next = RCI_TREE_RESET;
    end else if (dec_bus.tree_hit && req_op == RCI_OP_CLOSE) begin
      tree_next[dec_bus.tree_index] = 1'b1;
      tree_next[rci_tree_peer(dec_bus.tree_index)] = 1'b0;
    end else if (dec_bus.tree_hit && req_op == RCI_OP_OPEN) begin
      tree_next[dec_bus.tree_index] = 1'b0;
    end
  end

  // =========================================
  // switch state registers; undefined channels fall through unchanged
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_reg <= RCI_BANK_RESET;
      tree_reg <= RCI_TREE_RESET;
    end else begin
      bank_reg <= bank_next;
      tree_reg <= tree_next;
    end
  end

  // =========================================
  // backplane connection; isolation is static so it is just a gate
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tree_out_reg <= RCI_TREE_RESET;
      sense_live_reg <= 1'b0;
      source_live_reg <= 1'b0;
    end else begin
      tree_out_reg <= backplane_isolate_position ? 4'h0 : tree_next;
      // banks see a bus only through the bank tree switch, never directly
      sense_live_reg <= !backplane_isolate_position && tree_next[RCI_TREE_BANK_SENSE]
                        && (|bank_next);
      source_live_reg <= !backplane_isolate_position && tree_next[RCI_TREE_BANK_SOURCE]
                         && (|bank_next);
    end
  end

  // =========================================
  // request acknowledge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      accepted_reg <= 1'b0;
    end else begin
      accepted_reg <= (req_op == RCI_OP_RESET) ||
                      ((req_op == RCI_OP_CLOSE || req_op == RCI_OP_OPEN) &&
                       (dec_bus.bank_hit || dec_bus.tree_hit));
    end
  end

  // =========================================
  // outputs: one bit drives all three relays of a switch
  assign bank_sw_drive = bank_reg;
  assign tree_sw_drive = tree_reg;
  assign tree_backplane_drive = tree_out_reg;
  assign bank_sense_live = sense_live_reg;
  assign bank_source_live = source_live_reg;
  assign req_accepted = accepted_reg;

  // =========================================
  // checks
  // one request of a given kind for a given channel, as seen at a clock edge
  sequence s_close_req(logic [6:0] ch);
    req_op == RCI_OP_CLOSE && req_chan == ch;
  endsequence

  sequence s_open_req(logic [6:0] ch);
    req_op == RCI_OP_OPEN && req_chan == ch;
  endsequence

  // a close or open naming no defined switch; it must be refused
  sequence s_undef_req;
    (req_op == RCI_OP_CLOSE || req_op == RCI_OP_OPEN) &&
    !dec_bus.bank_hit && !dec_bus.tree_hit;
  endsequence

  a_lower_onehot: assert property (@(posedge core_clk) disable iff (sys_rst)
    $onehot0(bank_sw_drive[9:0])) else $error("lower bank has two channels closed");
  a_upper_onehot: assert property (@(posedge core_clk) disable iff (sys_rst)
    $onehot0(bank_sw_drive[19:10])) else $error("upper bank has two channels closed");
  a_sense_excl: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(tree_sw_drive[0] && tree_sw_drive[1])) else $error("both sense trees closed");
  a_source_excl: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(tree_sw_drive[2] && tree_sw_drive[3])) else $error("both source trees closed");
  a_close_upper: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_close_req(7'h13) |=> bank_sw_drive[19:10] == 10'h200)
    else $error("channel 19 close wrong");
  a_close_lower: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_close_req(7'h00) |=> bank_sw_drive[9:0] == 10'h001)
    else $error("channel 0 close wrong");
  a_close_91: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_close_req(RCI_CH_BANK_SENSE) |=> tree_sw_drive[0] && !tree_sw_drive[1])
    else $error("channel 91 close wrong");
  a_close_94: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_close_req(RCI_CH_BANK_SOURCE) |=> tree_sw_drive[3] && !tree_sw_drive[2])
    else $error("channel 94 close wrong");
  a_close_92: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_close_req(RCI_CH_THERM_SENSE) |=> tree_sw_drive[1] && !tree_sw_drive[0])
    else $error("channel 92 close wrong");
  a_close_93: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_close_req(RCI_CH_THERM_SOURCE) |=> tree_sw_drive[2] && !tree_sw_drive[3])
    else $error("channel 93 close wrong");
  // an open of channel 19 touches only that switch, whatever else is closed
  a_open_single: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_open_req(7'h13) |=> !bank_sw_drive[19] && $stable(bank_sw_drive[18:0])
    && $stable(tree_sw_drive)) else $error("channel 19 open touched another switch");
  a_reset_opens: assert property (@(posedge core_clk) disable iff (sys_rst)
    req_op == RCI_OP_RESET |=> bank_sw_drive == 20'h00000 && tree_sw_drive == 4'h0)
    else $error("reset request left a switch closed");
  a_reset_ack: assert property (@(posedge core_clk) disable iff (sys_rst)
    req_op == RCI_OP_RESET |=> req_accepted)
    else $error("reset request not acknowledged");
  a_isolate_cut: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(backplane_isolate_position) |-> tree_backplane_drive == 4'h0)
    else $error("isolated tree still on backplane");
  // in the enable position the backplane copy must track the tree state exactly
  a_enable_connect: assert property (@(posedge core_clk) disable iff (sys_rst)
    !$past(backplane_isolate_position) |-> tree_backplane_drive == tree_sw_drive)
    else $error("enabled tree not on backplane");
  a_undef_ignore: assert property (@(posedge core_clk) disable iff (sys_rst)
    (req_op != RCI_OP_RESET && !dec_bus.bank_hit && !dec_bus.tree_hit)
    |=> $stable(bank_sw_drive) && $stable(tree_sw_drive))
    else $error("undefined channel changed a switch");
  a_undef_refused: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_undef_req |=> !req_accepted)
    else $error("undefined channel acknowledged");
  a_bank_path: assert property (@(posedge core_clk) disable iff (sys_rst)
    bank_sense_live |-> tree_sw_drive[0] && (|bank_sw_drive))
    else $error("bank live without sense tree");
  a_source_path: assert property (@(posedge core_clk) disable iff (sys_rst)
    bank_source_live |-> tree_sw_drive[3] && (|bank_sw_drive))
    else $error("bank live without source tree");
endmodule

/* rtl/rci_pkg.sv */
// package of constants and types for the relay channel interlock
package rci_pkg;
  // =========================================
  // channel numbering
  localparam int RCI_NUM_SWITCHES = 24;
  localparam int RCI_BANK_SIZE = 10;
  localparam int RCI_NUM_BANK_SW = 20;
  localparam int RCI_NUM_TREE_SW = 4;
  localparam logic [6:0] RCI_CH_LOWER_FIRST = 7'h00;
  localparam logic [6:0] RCI_CH_LOWER_LAST = 7'h09;
  localparam logic [6:0] RCI_CH_UPPER_FIRST = 7'h0A;
  localparam logic [6:0] RCI_CH_UPPER_LAST = 7'h13;
  localparam logic [6:0] RCI_CH_BANK_SENSE = 7'h5B;
  localparam logic [6:0] RCI_CH_THERM_SENSE = 7'h5C;
  localparam logic [6:0] RCI_CH_THERM_SOURCE = 7'h5D;
  localparam logic [6:0] RCI_CH_BANK_SOURCE = 7'h5E;
  // =========================================
  // tree switch bit positions within the tree vector
  localparam int RCI_TREE_BANK_SENSE = 0;
  localparam int RCI_TREE_THERM_SENSE = 1;
  localparam int RCI_TREE_THERM_SOURCE = 2;
  localparam int RCI_TREE_BANK_SOURCE = 3;
  // =========================================
  // reset values: every switch open
  localparam logic [19:0] RCI_BANK_RESET = 20'h00000;
  localparam logic [3:0] RCI_TREE_RESET = 4'h0;
  // =========================================
  // request opcodes
  typedef enum logic [1:0] {
    RCI_OP_NONE,
    RCI_OP_CLOSE,
    RCI_OP_OPEN,
    RCI_OP_RESET
  } rci_op_t;
endpackage

/* rtl/rci_decode_if.sv */
// decoded channel request carried from the decoder to the switch state
`timescale 1ns/1ps
interface rci_decode_if;
  logic bank_hit;
  logic upper_bank;
  logic [3:0] bank_index;
  logic tree_hit;
  logic [1:0] tree_index;
  modport dec (output bank_hit, output upper_bank, output bank_index,
               output tree_hit, output tree_index);
  modport use_side (input bank_hit, input upper_bank, input bank_index,
                    input tree_hit, input tree_index);
endinterface

/* rtl/rci_chan_decode.sv */
// channel number decoder for the relay channel interlock
`timescale 1ns/1ps
module rci_chan_decode
  import rci_pkg::*;
(
  // channel number of the current request
  input wire logic [6:0] chan,
  // decoded result
  rci_decode_if.dec dec
);
  // =========================================
  // bank decode: lower 0..9, upper 10..19
  always_comb begin
    dec.bank_hit = 1'b0;
    dec.upper_bank = 1'b0;
    dec.bank_index = 4'h0;
    if (chan <= RCI_CH_LOWER_LAST) begin
      dec.bank_hit = 1'b1;
      dec.bank_index = chan[3:0];
    end else if (chan >= RCI_CH_UPPER_FIRST && chan <= RCI_CH_UPPER_LAST) begin
      dec.bank_hit = 1'b1;
      dec.upper_bank = 1'b1;
      dec.bank_index = 4'((chan - RCI_CH_UPPER_FIRST) & 7'h0F);
    end
  end

  // =========================================
  // tree decode: fixed channel numbers 91..94
  always_comb begin
    dec.tree_hit = 1'b1;
    dec.tree_index = 2'h0;
    unique case (chan)
      RCI_CH_BANK_SENSE: dec.tree_index = 2'(RCI_TREE_BANK_SENSE);
      RCI_CH_THERM_SENSE: dec.tree_index = 2'(RCI_TREE_THERM_SENSE);
      RCI_CH_THERM_SOURCE: dec.tree_index = 2'(RCI_TREE_THERM_SOURCE);
      RCI_CH_BANK_SOURCE: dec.tree_index = 2'(RCI_TREE_BANK_SOURCE);
      default: dec.tree_hit = 1'b0; // undefined numbers hit nothing
    endcase
  end
endmodule

/* sim/rci_host_model.sv */
// partner model: mainframe controller issuing channel requests
`timescale 1ns/1ps
module rci_host_model (
  // clock
  input wire logic core_clk,
  // request lines toward the card
  output rci_pkg::rci_op_t req_op,
  output logic [6:0] req_chan
);
  import rci_pkg::*;
  // ===========================================
  // idle lines at time zero
  initial begin
    req_op = RCI_OP_NONE;
    req_chan = 7'h00;
  end
  // one request per call, launched off the sampling edge; idle channel lines
  // carry the inverse so a stale number is never mistaken for a fresh one
  task automatic issue(input rci_op_t op, input logic [6:0] chan);
    @(negedge core_clk);
    req_op <= op;
    req_chan <= chan;
    @(negedge core_clk);
    req_op <= RCI_OP_NONE;
    req_chan <= ~chan;
  endtask
endmodule

/* sim/tb.sv */
// self-checking bench for the relay channel interlock
`timescale 1ns/1ps
module tb;
  import rci_pkg::*;
  logic core_clk;
  logic sys_rst;
  logic backplane_isolate_position;
  rci_op_t req_op;
  logic [6:0] req_chan;
  logic [19:0] bank_sw_drive;
  logic [3:0] tree_sw_drive;
  logic [3:0] tree_backplane_drive;
  logic bank_sense_live;
  logic bank_source_live;
  logic req_accepted;
  logic [19:0] exp_bank;
  logic [3:0] exp_tree;
  logic exp_acc;
  int miscompares;
  int cmp_count;
  // ===========================================
  // design and controller model
  rci_interlock DUT (.core_clk(core_clk), .sys_rst(sys_rst), .req_op(req_op),
    .req_chan(req_chan), .backplane_isolate_position(backplane_isolate_position),
    .bank_sw_drive(bank_sw_drive), .tree_sw_drive(tree_sw_drive),
    .tree_backplane_drive(tree_backplane_drive), .bank_sense_live(bank_sense_live),
    .bank_source_live(bank_source_live), .req_accepted(req_accepted));
  rci_host_model host (.core_clk(core_clk), .req_op(req_op), .req_chan(req_chan));
  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // verdict and end of run
  task automatic final_report();
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one comparison
  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // all outputs against the expected switch state
  task automatic check_all();
    logic iso;
    iso = backplane_isolate_position;
    check("bank_sw_drive", bank_sw_drive, exp_bank);
    check("tree_sw_drive", {16'h0000, tree_sw_drive}, {16'h0000, exp_tree});
    check("tree_backplane", {16'h0000, tree_backplane_drive},
          {16'h0000, iso ? 4'h0 : exp_tree});
    check("sense_live", {19'h00000, bank_sense_live},
          {19'h00000, !iso && exp_tree[0] && |exp_bank});
    check("source_live", {19'h00000, bank_source_live},
          {19'h00000, !iso && exp_tree[3] && |exp_bank});
    check("req_accepted", {19'h00000, req_accepted}, {19'h00000, exp_acc});
  endtask
  // send one request, then predict and compare; tree bits are ch91..ch94
  task automatic req(input rci_op_t op, input int ch);
    host.issue(op, 7'(ch));
    exp_acc = 1'b1;
    if (op == RCI_OP_RESET) begin
      exp_bank = 20'h00000;
      exp_tree = 4'h0;
    end else if (ch < 20) begin
      if (op == RCI_OP_CLOSE) exp_bank &= (ch < 10) ? 20'hFFC00 : 20'h003FF;
      exp_bank[ch] = (op == RCI_OP_CLOSE);
    end else if (ch >= 91 && ch <= 94) begin
      if (op == RCI_OP_CLOSE) exp_tree &= (ch < 93) ? 4'hC : 4'h3;
      exp_tree[ch - 91] = (op == RCI_OP_CLOSE);
    end else exp_acc = 1'b0;
    check_all();
  endtask
  // every bank channel back to back, then single opens
  task automatic t_banks();
    for (int ch = 0; ch < 20; ch++) req(RCI_OP_CLOSE, ch);
    req(RCI_OP_CLOSE, 4);
    req(RCI_OP_OPEN, 19);
    req(RCI_OP_OPEN, 19);
  endtask
  // tree switches of one type exclude each other
  task automatic t_trees();
    req(RCI_OP_CLOSE, 91);
    req(RCI_OP_CLOSE, 92);
    req(RCI_OP_CLOSE, 94);
    req(RCI_OP_CLOSE, 93);
    req(RCI_OP_CLOSE, 91);
    req(RCI_OP_OPEN, 93);
  endtask
  // undefined numbers at both edges of each gap change nothing
  task automatic t_undef();
    int bad[4] = '{20, 90, 95, 127};
    foreach (bad[i]) begin
      req(RCI_OP_CLOSE, bad[i]);
      req(RCI_OP_OPEN, bad[i]);
    end
  endtask
  // measurement sequences, isolation and both kinds of reset
  task automatic t_measure();
    req(RCI_OP_RESET, 0);
    req(RCI_OP_CLOSE, 91);
    req(RCI_OP_CLOSE, 6);
    req(RCI_OP_CLOSE, 94);
    backplane_isolate_position = 1'b1;
    exp_acc = 1'b0;
    @(negedge core_clk);
    check_all();
    backplane_isolate_position = 1'b0;
    req(RCI_OP_CLOSE, 92);
    req(RCI_OP_CLOSE, 93);
    sys_rst = 1'b1;
    @(negedge core_clk);
    sys_rst = 1'b0;
    exp_bank = 20'h00000;
    exp_tree = 4'h0;
    exp_acc = 1'b0;
    check_all();
  endtask
  // main sequence: reset for five cycles, then the scenarios
  initial begin
    sys_rst = 1'b1;
    backplane_isolate_position = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    exp_bank = 20'h00000;
    exp_tree = 4'h0;
    exp_acc = 1'b0;
    repeat (5) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    check_all();
    t_banks();
    t_trees();
    t_undef();
    t_measure();
    final_report();
  end
  // watchdog: 43 requests are expected, so 5000 cycles is ample
  initial begin
    #(50 * 5000);
    miscompares++;
    final_report();
  end
endmodule
